//--- hdl/idfrf_pkg.sv
// idfrf_pkg: register map, flag positions, command bits, rate format and timing
// for the diagnostic flag and angular rate block.
// assumes a 10 MHz core clock and a 16-bit word serial register port.
package idfrf_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 10_000_000;
  localparam int STANDBY_MS     = 250;
  localparam int STANDBY_CYCLES = STANDBY_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // serial frame
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS = 16;
  localparam int          RW_BIT     = 15;
  localparam int          ADDR_W     = 7;
  localparam logic [3:0]  LAST_BIT   = 4'hF;
  localparam logic [3:0]  FIRST_BIT  = 4'h0;

  // ----------------------------------------------------------------
  // register map (byte addresses, word at even address)
  // ----------------------------------------------------------------
  localparam logic [6:0] DIAG_ADDR     = 7'h02;
  localparam logic [6:0] RATE_FIRST    = 7'h04;
  localparam logic [6:0] RATE_LAST     = 7'h0F;
  localparam logic [6:0] MISC_ADDR_LO  = 7'h60;
  localparam logic [6:0] MISC_ADDR_HI  = 7'h61;
  localparam logic [6:0] GCMD_ADDR_LO  = 7'h68;

  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic [15:0] MISC_RESET = 16'h00C1;
  localparam logic [15:0] FLAG_MASK  = 16'h00FE;
  localparam logic [15:0] READ_ZERO  = 16'h0000;

  // ----------------------------------------------------------------
  // flag positions
  // ----------------------------------------------------------------
  localparam int FLG_CLOCK    = 7;
  localparam int FLG_MEMORY   = 6;
  localparam int FLG_SENSOR   = 5;
  localparam int FLG_STANDBY  = 4;
  localparam int FLG_FRAMING  = 3;
  localparam int FLG_UPDATE   = 2;
  localparam int FLG_OVERRUN  = 1;

  // ----------------------------------------------------------------
  // misc control and global command fields
  // ----------------------------------------------------------------
  localparam int         SYNC_MODE_LSB = 2;
  localparam int         SYNC_MODE_MSB = 4;
  localparam logic [2:0] SYNC_SCALED   = 3'h2;
  localparam int CMD_SELF_TEST    = 2;
  localparam int CMD_FLASH_UPDATE = 3;
  localparam int CMD_FLASH_TEST   = 4;
  localparam int CMD_SOFT_RESET   = 7;

  // ----------------------------------------------------------------
  // rate format
  // ----------------------------------------------------------------
  localparam int                 RATE_W      = 32;
  localparam int                 RATE_AXES   = 3;
  localparam int                 PROD_W      = 41;
  localparam logic signed [40:0] RATE_POS_FS = 41'sh000_4E20_0000;
  localparam logic signed [40:0] RATE_NEG_FS = -41'sh000_4E20_0000;
  localparam logic [7:0]         KG_125      = 8'hA0;
  localparam logic [7:0]         KG_500      = 8'h28;
  localparam logic [7:0]         KG_2000     = 8'h0A;

  typedef enum logic [1:0] {
    IDFRF_MODEL_125  = 2'h0,
    IDFRF_MODEL_500  = 2'h1,
    IDFRF_MODEL_2000 = 2'h2
  } idfrf_model_t;

  typedef enum logic [1:0] {
    IDFRF_RUN  = 2'h0,
    IDFRF_LOW  = 2'h1,
    IDFRF_WAIT = 2'h3
  } idfrf_power_t;

  function automatic logic [7:0] idfrf_scale(input idfrf_model_t model);
    case (model)
      IDFRF_MODEL_125: idfrf_scale = KG_125;
      IDFRF_MODEL_500: idfrf_scale = KG_500;
      default:         idfrf_scale = KG_2000;
    endcase
  endfunction

endpackage

//--- hdl/idfrf_rate_mem.sv
// idfrf_rate_mem: small word store for the per-axis rate samples.
// assumes all axes are written together; read data come out of a register one cycle later.
`timescale 1ns/100ps
module idfrf_rate_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 3
) (
  input  wire logic                     clk_i,     // core clock
  input  wire logic                     sys_rst_i, // async reset, high
  input  wire logic                     wr_en_i,   // write all entries
  input  wire logic [DEPTH*WIDTH-1:0]   wr_data_i, // entry i at [i*WIDTH +: WIDTH]
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,  // read entry
  output logic      [WIDTH-1:0]         rd_data_o  // registered read data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rd;

  always_comb
  begin
    next_rd = (int'(rd_idx_i) < DEPTH) ? mem[rd_idx_i] : '0;
  end

  // storage holds no reset: contents are undefined until the first sample
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= wr_data_i[i*WIDTH +: WIDTH];
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rd_data_o <= '0;
    end
    else
    begin
      rd_data_o <= next_rd;
    end
  end

endmodule

//--- hdl/idfrf_sync3.sv
// idfrf_sync3: three-stage pin synchroniser with agreement filter.
// assumes inputs asynchronous to clk_i; output changes only when stages two and three agree.
`timescale 1ns/100ps
module idfrf_sync3 #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,     // core clock
  input  wire logic             sys_rst_i, // async reset, high
  input  wire logic [WIDTH-1:0] pin_i,     // raw pin levels
  output logic      [WIDTH-1:0] level_o    // filtered levels
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_o[i];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stage1  <= RST_VAL;
      stage2  <= RST_VAL;
      stage3  <= RST_VAL;
      level_o <= RST_VAL;
    end
    else
    begin
      stage1  <= pin_i;
      stage2  <= stage1;
      stage3  <= stage2;
      level_o <= next_level;
    end
  end

endmodule

//--- hdl/idfrf_top.sv
// idfrf_top: sticky diagnostic flags and angular rate registers behind the serial port.
// assumes serial mode 3 (clock idles high, sample on rise), 16-bit words,
// a read answered in the following word, and sensor/flash logic on clk_i.
`timescale 1ns/100ps

// Contract
// RL1: clock error flag bit 7 on sync lock loss, only in scaled sync mode.
// RL2: flash test CRC mismatch sets flag bit 6.
// RL3: self test ending with a failed sensor sets flag bit 5.
// RL4: low supply sets bit 4, halts data; resume after 250 ms good supply.
// RL5: transfer clock count not a multiple of 16 sets flag bit 3.
// RL6: failed flash update sets flag bit 2.
// RL7: data path overrun sets flag bit 1.
// RL8: host resets device after overrun, by pin or command bit 7.
// RL9: reading the flag register clears all its bits.
// RL10: flags stay set until a read clears them.
// RL11: a condition still present after the clearing read sets its flag again.
// RL12: host repeats its last sequence after a framing error.
// RL13: host retries failed flash update with supply at least 3 V.
// RL14: rate is 32-bit two's complement split into high and low words.
// RL15: high word scaled 160, 40 or 10 counts per deg/s by model.
// RL16: 16-bit full scale 0x4E20 and 0xB1E0, zero as 0x0000.
// RL17: 32-bit full scale 0x4E200000 and 0xB1E00000, step divided by 2^16.
// RL18: low word holds the 16 extra resolution bits.
// RL19: reserved flag bits 15..8 and 0 read zero and never set.
module idfrf_top #(
  parameter idfrf_pkg::idfrf_model_t MODEL          = idfrf_pkg::IDFRF_MODEL_125,
  parameter int                      STANDBY_CYCLES = idfrf_pkg::STANDBY_CYCLES
) (
  input  wire logic                   clk_i,                // core clock, 10 MHz
  input  wire logic                   sys_rst_i,            // async reset, high
  input  wire logic                   sclk_i,               // serial clock pin
  input  wire logic                   cs_n_i,               // serial select pin, low active
  input  wire logic                   mosi_i,               // serial data in pin
  output logic                        miso_o,               // serial data out
  input  wire logic                   supply_low_i,         // supply comparator, high below 2.8 V
  input  wire logic                   sync_unlock_i,        // sample clock not locked to sync input
  input  wire logic                   self_test_done_i,     // self test finished, pulse
  input  wire logic                   self_test_fail_i,     // self test result, with done
  input  wire logic                   flash_test_done_i,    // flash test finished, pulse
  input  wire logic                   flash_crc_match_i,    // flash CRC matches stored, with done
  input  wire logic                   flash_update_done_i,  // flash update finished, pulse
  input  wire logic                   flash_update_ok_i,    // flash update result, with done
  input  wire logic                   overrun_i,            // data path overrun, level or pulse
  input  wire logic                   rate_valid_i,         // new rate sample, pulse
  input  wire logic signed [idfrf_pkg::RATE_W-1:0] rate_x_i, // x rate, deg/s with 16 fraction bits
  input  wire logic signed [idfrf_pkg::RATE_W-1:0] rate_y_i, // y rate, same format
  input  wire logic signed [idfrf_pkg::RATE_W-1:0] rate_z_i, // z rate, same format
  output logic                        self_test_start_o,    // start self test, pulse
  output logic                        flash_test_start_o,   // start flash test, pulse
  output logic                        flash_update_start_o, // start flash update, pulse
  output logic                        soft_reset_o,         // software reset request, pulse
  output logic                        halt_o,               // data processing stopped
  output logic                        reinit_o,             // reinitialise after standby, pulse
  output logic [2:0]                  sync_mode_o           // sync mode field of misc control
);

  import idfrf_pkg::*;

  localparam int TMR_W = $clog2(STANDBY_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(STANDBY_CYCLES - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic supply_low_s;

  idfrf_sync3 #(
    .WIDTH   (4),
    .RST_VAL (4'hE)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     ({sclk_i, cs_n_i, supply_low_i, mosi_i}),
    .level_o   ({sclk_s, cs_n_s, supply_low_s, mosi_s})
  );

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  logic        sclk_d;
  logic        cs_n_d;
  logic [3:0]  bit_cnt;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [3:0]  next_bit_cnt;
  logic [15:0] next_rx;
  logic [15:0] next_tx;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        frame_end;
  logic        frame_done;
  logic        framing_err;
  logic [15:0] word;
  logic [6:0]  addr;
  logic        is_write;
  logic [15:0] rd_load;
  logic        rd_clear;
  logic        rate_sel;
  logic        rate_pend;
  logic        rate_hi;
  logic        next_rate_pend;
  logic        next_rate_hi;
  logic [1:0]  rate_axis;
  logic [6:0]  rate_off;
  logic [RATE_W-1:0] rate_rd;
  logic [15:0] misc_ctrl;
  logic [15:0] diag_flags;

  assign sclk_rise   = sclk_s & ~sclk_d & ~cs_n_s;
  assign sclk_fall   = ~sclk_s & sclk_d & ~cs_n_s;
  assign frame_end   = cs_n_s & ~cs_n_d;
  assign frame_done  = sclk_rise && (bit_cnt == LAST_BIT);
  assign framing_err = frame_end && (bit_cnt != FIRST_BIT); // RL5
  assign word        = {rx_shift[14:0], mosi_s};
  assign addr        = word[14:8];
  assign is_write    = word[RW_BIT];
  assign rate_off    = addr - RATE_FIRST;
  assign rate_sel    = (addr >= RATE_FIRST) && (addr <= RATE_LAST);
  assign rate_axis   = rate_off[3:2];
  assign miso_o      = tx_shift[FRAME_BITS-1];

  // read answer for the next word; rate words wait one cycle for the store
  always_comb
  begin
    rd_load  = READ_ZERO;
    rd_clear = 1'b0;
    if ({addr[6:1], 1'b0} == DIAG_ADDR)
    begin
      rd_load  = diag_flags & FLAG_MASK;
      rd_clear = frame_done && !is_write; // RL9
    end
    else if ({addr[6:1], 1'b0} == MISC_ADDR_LO)
    begin
      rd_load = misc_ctrl;
    end
  end

  always_comb
  begin
    next_bit_cnt   = bit_cnt;
    next_rx        = rx_shift;
    next_tx        = tx_shift;
    next_rate_pend = 1'b0;
    next_rate_hi   = rate_hi;
    if (cs_n_s)
    begin
      next_bit_cnt = FIRST_BIT;
    end
    else if (sclk_rise)
    begin
      next_rx      = word;
      next_bit_cnt = bit_cnt + 4'h1;
    end
    // first falling edge of a word keeps the bit already on the line
    if (sclk_fall && bit_cnt != FIRST_BIT)
    begin
      next_tx = {tx_shift[14:0], 1'b0};
    end
    if (frame_done)
    begin
      next_tx = is_write ? READ_ZERO : rd_load;
      if (!is_write && rate_sel)
      begin
        next_rate_pend = 1'b1;
        next_rate_hi   = rate_off[1]; // RL14
      end
    end
    if (rate_pend)
    begin
      next_tx = rate_hi ? rate_rd[31:16] : rate_rd[15:0]; // RL18
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sclk_d    <= 1'b1;
      cs_n_d    <= 1'b1;
      bit_cnt   <= FIRST_BIT;
      rx_shift  <= READ_ZERO;
      tx_shift  <= READ_ZERO;
      rate_pend <= 1'b0;
      rate_hi   <= 1'b0;
    end
    else
    begin
      sclk_d    <= sclk_s;
      cs_n_d    <= cs_n_s;
      bit_cnt   <= next_bit_cnt;
      rx_shift  <= next_rx;
      tx_shift  <= next_tx;
      rate_pend <= next_rate_pend;
      rate_hi   <= next_rate_hi;
    end
  end

  // ----------------------------------------------------------------
  // writable control and command pulses
  // ----------------------------------------------------------------
  logic [15:0] next_misc;
  logic [7:0]  next_cmd;
  logic [7:0]  cmd_pulse;

  always_comb
  begin
    next_misc = misc_ctrl;
    next_cmd  = 8'h00;
    if (frame_done && is_write)
    begin
      if (addr == MISC_ADDR_LO)
      begin
        next_misc[7:0] = word[7:0];
      end
      if (addr == MISC_ADDR_HI)
      begin
        next_misc[15:8] = word[7:0];
      end
      if (addr == GCMD_ADDR_LO)
      begin
        next_cmd = word[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      misc_ctrl <= MISC_RESET;
      cmd_pulse <= 8'h00;
    end
    else
    begin
      misc_ctrl <= next_misc;
      cmd_pulse <= next_cmd;
    end
  end

  assign sync_mode_o          = misc_ctrl[SYNC_MODE_MSB:SYNC_MODE_LSB];
  assign self_test_start_o    = cmd_pulse[CMD_SELF_TEST];    // RL3
  assign flash_update_start_o = cmd_pulse[CMD_FLASH_UPDATE]; // RL6
  assign flash_test_start_o   = cmd_pulse[CMD_FLASH_TEST];   // RL2
  assign soft_reset_o         = cmd_pulse[CMD_SOFT_RESET];   // RL8

  // ----------------------------------------------------------------
  // standby on low supply
  // ----------------------------------------------------------------
  idfrf_power_t     pwr_state;
  idfrf_power_t     next_pwr;
  logic [TMR_W-1:0] good_tmr;
  logic [TMR_W-1:0] next_tmr;
  logic             next_reinit;

  always_comb
  begin
    next_pwr    = pwr_state;
    next_tmr    = good_tmr;
    next_reinit = 1'b0;
    unique case (pwr_state)
      IDFRF_RUN:
      begin
        if (supply_low_s)
        begin
          next_pwr = IDFRF_LOW;
        end
      end
      IDFRF_LOW:
      begin
        next_tmr = '0;
        if (!supply_low_s)
        begin
          next_pwr = IDFRF_WAIT;
        end
      end
      IDFRF_WAIT:
      begin
        // any dip restarts the full good-supply interval
        if (supply_low_s)
        begin
          next_pwr = IDFRF_LOW;
        end
        else if (good_tmr == TMR_LAST)
        begin
          next_pwr    = IDFRF_RUN;
          next_reinit = 1'b1; // RL4
        end
        else
        begin
          next_tmr = good_tmr + 1'b1;
        end
      end
      default:
      begin
        next_pwr = IDFRF_LOW;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pwr_state <= IDFRF_RUN;
      good_tmr  <= '0;
      reinit_o  <= 1'b0;
    end
    else
    begin
      pwr_state <= next_pwr;
      good_tmr  <= next_tmr;
      reinit_o  <= next_reinit;
    end
  end

  assign halt_o = (pwr_state != IDFRF_RUN); // RL4

  // ----------------------------------------------------------------
  // sticky diagnostic flags
  // ----------------------------------------------------------------
  logic [15:0] flag_set;
  logic [15:0] next_flags;

  always_comb
  begin
    flag_set              = 16'h0000;
    flag_set[FLG_CLOCK]   = sync_unlock_i && (sync_mode_o == SYNC_SCALED); // RL1
    flag_set[FLG_MEMORY]  = flash_test_done_i && !flash_crc_match_i;       // RL2
    flag_set[FLG_SENSOR]  = self_test_done_i && self_test_fail_i;          // RL3
    flag_set[FLG_STANDBY] = supply_low_s;                                  // RL4
    flag_set[FLG_FRAMING] = framing_err;                                   // RL5
    flag_set[FLG_UPDATE]  = flash_update_done_i && !flash_update_ok_i;     // RL6
    flag_set[FLG_OVERRUN] = overrun_i;                                     // RL7
    // a set in the clearing cycle wins, so a lasting condition re-flags at once
    next_flags = (rd_clear ? 16'h0000 : diag_flags) | flag_set;           // RL10 RL11
    next_flags = next_flags & FLAG_MASK;                                  // RL19
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      diag_flags <= DIAG_RESET;
    end
    else
    begin
      diag_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // rate scaling and store
  // ----------------------------------------------------------------
  // input is deg/s with 16 fraction bits; times the model factor gives
  // counts of 1/(K*2^16) deg/s, clamped to the documented full scale
  function automatic logic [RATE_W-1:0] clamp_rate(input logic signed [RATE_W-1:0] rate);
    logic signed [PROD_W-1:0] prod;
    prod = PROD_W'(rate) * $signed({1'b0, idfrf_scale(MODEL)}); // RL15
    if (prod > RATE_POS_FS)
    begin
      clamp_rate = RATE_POS_FS[RATE_W-1:0]; // RL16 RL17
    end
    else if (prod < RATE_NEG_FS)
    begin
      clamp_rate = RATE_NEG_FS[RATE_W-1:0]; // RL16 RL17
    end
    else
    begin
      clamp_rate = prod[RATE_W-1:0]; // RL14
    end
  endfunction

  logic [RATE_AXES*RATE_W-1:0] rate_wr;

  assign rate_wr = {clamp_rate(rate_z_i), clamp_rate(rate_y_i), clamp_rate(rate_x_i)};

  idfrf_rate_mem #(
    .WIDTH (RATE_W),
    .DEPTH (RATE_AXES)
  ) u_rate_mem (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (rate_valid_i && !halt_o), // RL4
    .wr_data_i (rate_wr),
    .rd_idx_i  (rate_axis),
    .rd_data_o (rate_rd)
  );

endmodule

//--- sim/idfrf_host_model.sv
// idfrf_host_model: serial master, clock idles high, 800 ns period.
// assumes one caller at a time, entering on a core clock falling edge.
`timescale 1ns/100ps
module idfrf_host_model (
  output logic     sclk_o, // serial clock
  output logic     cs_n_o, // select
  output logic     mosi_o, // data out
  input wire logic miso_i  // data in
);
  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // sends the top n bits of w; miso taken late in the high phase
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = '0;
    #23 cs_n_o = 1'b0;
    #400;
    for (int i = 0; i < n; i++)
    begin
      sclk_o = 1'b0;
      mosi_o = w[31-i];
      #400 sclk_o = 1'b1;
      #400 r = {r[30:0], miso_i};
    end
    cs_n_o = 1'b1;
    // a released line must not keep its last level
    mosi_o = ~mosi_o;
    #800;
  endtask
endmodule

//--- sim/idfrf_top_asserts.sv
// idfrf_top_asserts: port checks of standby, command pulses and idle serial port.
// assumes binding to idfrf_top with the same STANDBY_CYCLES.
`timescale 1ns/100ps
module idfrf_top_asserts #(
  parameter int STANDBY_CYCLES = 20
) (
  input wire logic       clk_i,                // clock
  input wire logic       sys_rst_i,            // reset
  input wire logic       cs_n_i,               // select
  input wire logic       supply_low_i,         // supply low
  input wire logic       miso_o,               // data out
  input wire logic       halt_o,               // halted
  input wire logic       reinit_o,             // reinit
  input wire logic [2:0] sync_mode_o,          // sync field
  input wire logic       self_test_start_o,    // command
  input wire logic       flash_test_start_o,   // command
  input wire logic       flash_update_start_o, // command
  input wire logic       soft_reset_o          // command
);
  int   good_cnt;
  int   next_good_cnt;
  logic cmd;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  assign cmd = self_test_start_o | flash_test_start_o | flash_update_start_o | soft_reset_o;
  // saturates so a long good spell cannot wrap
  always_comb next_good_cnt = supply_low_i ? 0 : (good_cnt < 4096 ? good_cnt + 1 : good_cnt);
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      good_cnt <= 0;
    else
      good_cnt <= next_good_cnt;
  AST_HALT_LOW: assert property (supply_low_i [*8] |-> halt_o)
    else $error("no halt on low supply");
  AST_EARLY_RESUME: assert property ($fell(halt_o) |-> good_cnt >= STANDBY_CYCLES)
    else $error("resumed too early");
  AST_LATE_RESUME: assert property (good_cnt == STANDBY_CYCLES + 10 |-> !halt_o)
    else $error("resume missing");
  AST_REINIT_ON_RESUME: assert property ($fell(halt_o) |-> ##[0:1] reinit_o)
    else $error("no reinit on resume");
  AST_REINIT_PULSE: assert property (reinit_o |=> !reinit_o)
    else $error("reinit too long");
  AST_SYNC_HOLD: assert property (cs_n_i [*8] |=> $stable(sync_mode_o))
    else $error("sync field moved while idle");
  AST_MISO_HOLD: assert property (cs_n_i [*8] |=> $stable(miso_o))
    else $error("data out moved while idle");
  AST_CMD_PULSE: assert property (cmd |=> !cmd)
    else $error("command pulse too long");
  AST_CMD_QUIET: assert property (cs_n_i [*8] |-> !cmd)
    else $error("command with no transfer");
endmodule
bind idfrf_top idfrf_top_asserts #(.STANDBY_CYCLES(STANDBY_CYCLES)) u_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .supply_low_i(supply_low_i),
  .miso_o(miso_o), .halt_o(halt_o), .reinit_o(reinit_o), .sync_mode_o(sync_mode_o),
  .self_test_start_o(self_test_start_o), .flash_test_start_o(flash_test_start_o),
  .flash_update_start_o(flash_update_start_o), .soft_reset_o(soft_reset_o));

//--- sim/imu_diag_flags_and_rate_format_tb.sv
// imu_diag_flags_and_rate_format_tb: self-checking bench for idfrf_top.
// assumes idfrf_host_model on the serial port and the bound checker.
`timescale 1ns/100ps
module imu_diag_flags_and_rate_format_tb;
  import idfrf_pkg::*;
  localparam int STB = 20;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sclk, cs_n, mosi, miso, halt, reinit;
  logic sup_low = 0, unlock = 0, st_done = 0, st_fail = 0, ft_done = 0, crc_ok = 0;
  logic fu_done = 0, fu_ok = 0, ovr = 0, rv = 0;
  logic signed [31:0] rx = 0, ry = 0, rz = 0;
  logic [3:0] seen = 0;
  logic [3:0] cmd;
  logic [2:0] sync_mode;
  int n_mismatch = 0;
  int tests_run = 0;
  always #50 clk_i = ~clk_i;
  idfrf_top #(.MODEL(IDFRF_MODEL_125), .STANDBY_CYCLES(STB)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
    .supply_low_i(sup_low), .sync_unlock_i(unlock), .self_test_done_i(st_done), .self_test_fail_i(st_fail),
    .flash_test_done_i(ft_done), .flash_crc_match_i(crc_ok), .flash_update_done_i(fu_done),
    .flash_update_ok_i(fu_ok), .overrun_i(ovr), .rate_valid_i(rv), .rate_x_i(rx), .rate_y_i(ry),
    .rate_z_i(rz), .self_test_start_o(cmd[0]), .flash_update_start_o(cmd[1]), .flash_test_start_o(cmd[2]),
    .soft_reset_o(cmd[3]), .halt_o(halt), .reinit_o(reinit), .sync_mode_o(sync_mode));
  idfrf_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  always @(posedge clk_i) seen <= sys_rst_i ? 4'h0 : seen | cmd;
  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    logic [31:0] r;
    host.xfer({1'b0, a, 24'h0}, 32, r);
    @(negedge clk_i);
    chk("read", r[15:0], e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] r;
    host.xfer({1'b1, a, d, 16'h0}, 16, r);
    @(negedge clk_i);
  endtask
  // q selects the failing outcome of event k
  task automatic ev(input int k, input logic q);
    st_fail = q;
    crc_ok = ~q;
    fu_ok = ~q;
    {st_done, ft_done, fu_done, ovr} = {k == 0, k == 1, k == 2, k == 3 && q};
    @(negedge clk_i);
    {st_done, ft_done, fu_done, ovr} = '0;
  endtask
  task automatic pulse_rate();
    rv = 1;
    @(negedge clk_i);
    rv = 0;
  endtask
  function automatic logic [15:0] ex(input logic signed [31:0] v, input int h);
    longint p;
    p = longint'(v) * 160;
    if (p > 64'sh4E20_0000) p = 64'sh4E20_0000;
    if (p < -64'sh4E20_0000) p = -64'sh4E20_0000;
    return h ? p[31:16] : p[15:0];
  endfunction
  initial
  begin
    #5_000_000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    logic [31:0] r;
    int fb[4] = '{5, 6, 2, 1};
    int cb[4] = '{2, 3, 4, 7};
    r = $urandom(69667);
    repeat (4) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (STB + 20) @(negedge clk_i);
    host.xfer({1'b0, 7'h02, 24'h0}, 32, r);
    @(negedge clk_i);
    rdchk(7'h02, 16'h0000);
    rdchk(7'h60, 16'h00C1);
    rdchk(7'h30, 16'h0000);
    rdchk(7'h68, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      ev(k, 1'b0);
      rdchk(7'h02, 16'h0000);
      ev(k, 1'b1);
      rdchk(7'h02, 16'h0001 << fb[k]);
      rdchk(7'h02, 16'h0000);
    end
    host.xfer(32'h0, 20, r);
    @(negedge clk_i);
    rdchk(7'h02, 16'h0008);
    host.xfer(32'h0, 32, r);
    @(negedge clk_i);
    rdchk(7'h02, 16'h0000);
    wr(7'h60, 8'hC9);
    chk("sync_mode", sync_mode, 32'h2);
    unlock = 1;
    rdchk(7'h02, 16'h0080);
    rdchk(7'h02, 16'h0080);
    unlock = 0;
    rdchk(7'h02, 16'h0080);
    rdchk(7'h02, 16'h0000);
    wr(7'h60, 8'hC1);
    unlock = 1;
    rdchk(7'h02, 16'h0000);
    unlock = 0;
    for (int j = 0; j < 4; j++)
    begin
      wr(7'h68, 8'h01 << cb[j]);
      chk("command", seen, (32'h2 << j) - 1);
    end
    for (int i = 0; i < 6; i++)
    begin
      rx = i == 0 ? 32'sh007D_0000 : i == 1 ? -32'sh007D_0000 : i == 2 ? 32'sh0000_0001 :
           i == 3 ? 32'sh0 : $signed($urandom) >>> (3 * i);
      ry = -(rx <<< 1);
      rz = rx >>> 4;
      pulse_rate();
      for (int a = 0; a < 6; a++)
        rdchk(7'h04 + 7'(2 * a), ex(a < 2 ? rx : a < 4 ? ry : rz, a % 2));
    end
    sup_low = 1;
    repeat (12) @(negedge clk_i);
    chk("halt", halt, 32'h1);
    r = rz;
    rz = 32'sh0001_0000;
    pulse_rate();
    rz = r;
    sup_low = 0;
    repeat (STB + 15) @(negedge clk_i);
    chk("halt", halt, 32'h0);
    rdchk(7'h02, 16'h0010);
    rdchk(7'h0E, ex(rz, 1));
    complete_run();
  end
endmodule
